//--- dv/hpc_host.sv
`timescale 1ns/100ps
`default_nettype none
module hpc_host (
    input wire hpc_pkg::host_req_t cmd,
    output var hpc_pkg::host_req_t req
);
    // a write wins, so the two strobes never rise together
    always_comb
    begin
        req = cmd;
        req.rd = cmd.rd && !cmd.wr;
    end
endmodule
`default_nettype wire

//--- dv/hpc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module hpc_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic access_fail,
    input wire hpc_pkg::host_req_t req,
    input wire hpc_pkg::host_rsp_t rsp,
    input wire logic [7:0] phase_mem_code,
    input wire logic [7:0] page_sel_out,
    input wire logic page_valid,
    input wire logic [14:0] int_addr,
    input wire logic lockout
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rd; req.rd |=> rsp.valid; endproperty
    a_rd: assert property (p_rd) else $error("no reply");
    property p_nrd; !req.rd |=> !rsp.valid; endproperty
    a_nrd: assert property (p_nrd) else $error("stray reply");
    property p_sat; phase_mem_code <= hpc_pkg::PHASE_MEM_MAX_CODE; endproperty
    a_sat: assert property (p_sat) else $error("code too big");
    property p_pg; !$past(sys_rst) && $past(page_sel_out) >= hpc_pkg::PAGE_FIRST_RSVD
        |-> !page_valid; endproperty
    a_pg: assert property (p_pg) else $error("page flag");
    property p_adr; !$past(sys_rst) |-> int_addr == {$past(page_sel_out), $past(req.addr)};
    endproperty
    a_adr: assert property (p_adr) else $error("bad address");
    property p_lk; lockout && req.wr && req.addr == hpc_pkg::SELECT_LOW_ADDR
        |=> $stable(page_sel_out); endproperty
    a_lk: assert property (p_lk) else $error("locked write");
    property p_wr; req.wr && !access_fail && !lockout && req.addr == hpc_pkg::SELECT_LOW_ADDR
        |=> page_sel_out == $past(req.wdata); endproperty
    a_wr: assert property (p_wr) else $error("page write");
    property p_gd; req.wr && !access_fail && req.addr == hpc_pkg::GUARD_LOW_ADDR
        |=> lockout == $past(req.wdata[hpc_pkg::LOCKOUT_BIT]); endproperty
    a_gd: assert property (p_gd) else $error("guard write");
    c_lk: cover property (lockout && req.wr);
    c_pg: cover property (!page_valid);
    c_sat: cover property (phase_mem_code == 8'hA0);
endmodule
bind paged_host_port_control hpc_monitor mon (
    .clk(clk),
    .sys_rst(sys_rst),
    .access_fail(access_fail),
    .req(req),
    .rsp(rsp),
    .phase_mem_code(phase_mem_code),
    .page_sel_out(page_sel_out),
    .page_valid(page_valid),
    .int_addr(int_addr),
    .lockout(lockout)
);
`default_nettype wire

//--- dv/test_paged_host_port_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_paged_host_port_control;
    logic clk = 0, sys_rst = 1, access_fail = 0, page_valid, lockout, f;
    hpc_pkg::host_req_t cmd = '0, req;
    hpc_pkg::host_rsp_t rsp;
    logic [7:0] phase_mem_code, page_sel_out, d, v, e = 8'h1B;
    logic [14:0] int_addr;
    int miscompares = 0, comparisons = 0, seed = 32'h8e7f, i;
    hpc_host host (
        .cmd(cmd),
        .req(req)
    );
    paged_host_port_control DUT (
        .clk(clk),
        .sys_rst(sys_rst),
        .req(req),
        .access_fail(access_fail),
        .rsp(rsp),
        .phase_mem_code(phase_mem_code),
        .page_sel_out(page_sel_out),
        .page_valid(page_valid),
        .int_addr(int_addr),
        .lockout(lockout)
    );
    function automatic logic [7:0] exp_code(input logic [7:0] c);
        exp_code = c > 8'hA0 ? 8'hA0 : c;
    endfunction
    function automatic logic [14:0] page_addr(input logic [7:0] p, input logic [6:0] a);
        page_addr = p * 15'h0080 + a;
    endfunction
    initial forever #5 clk = ~clk;
    task chk(input logic [16:0] g, input logic [16:0] x);
        comparisons++;
        if (g !== x) begin miscompares++; $display("[FAIL] %0t got %h want %h", $time, g, x); end
    endtask
    task close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task acc(input logic w, input logic fl, input logic [6:0] a, input logic [7:0] wd);
        @(negedge clk);
        cmd = '{w, !w, a, wd};
        access_fail = fl;
        @(negedge clk);
        d = rsp.rdata;
        if (!w) chk(rsp.valid, 1);
        cmd = '{1'b0, 1'b0, a, wd};
        access_fail = 0;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 0;
        chk({lockout, page_sel_out, phase_mem_code}, 17'h0001B);
        acc(1, 0, 7'h7F, 8'h0B);
        for (i = 0; i < 40; i++) begin
            // any code is stored; the reference period is the host's concern
            v = i < 3 ? 8'hA0 + i : $random(seed);
            f = i > 2 && $random(seed) % 3 == 0;
            acc(1, f, 7'h1A, v);
            if (!f) e = v;
            acc(0, 0, 7'h1A, 8'h00);
            chk(d, e);
            chk(int_addr, page_addr(8'h0B, 7'h1A));
            chk(phase_mem_code, exp_code(e));
        end
        for (i = 0; i < 16; i++) begin
            acc(1, 0, 7'h7F, i);
            acc(0, 0, 7'h7F, 8'h00);
            chk({d, page_valid}, {i[7:0], i < 7 || i == 8 || (i > 9 && i < 14)});
        end
        acc(1, 0, 7'h7F, 8'h0B);
        acc(1, 0, 7'h7E, 8'h80);
        acc(1, 0, 7'h1A, 8'h55);
        acc(1, 0, 7'h7F, 8'h02);
        acc(0, 0, 7'h1A, 8'h00);
        chk({lockout, page_sel_out, d}, {1'b1, 8'h0B, e});
        acc(1, 0, 7'h7E, 8'h00);
        chk(lockout, 0);
        acc(0, 1, 7'h1A, 8'h00);
        acc(0, 0, 7'h7E, 8'h00);
        chk(d, 8'h01);
        acc(0, 0, 7'h7E, 8'h00);
        chk(d, 8'h00);
        close_out;
    end
    initial begin
        #100000;
        miscompares++;
        close_out;
    end
endmodule
`default_nettype wire

//--- hdl/paged_host_port_control.sv
`timescale 1ns/100ps
`default_nettype none
module paged_host_port_control (
    input wire logic clk,
    input wire logic sys_rst,
    input wire hpc_pkg::host_req_t req,
    input wire logic access_fail,
    output var hpc_pkg::host_rsp_t rsp,
    output logic [7:0] phase_mem_code,
    output logic [7:0] page_sel_out,
    output logic page_valid,
    output logic [14:0] int_addr,
    output logic lockout
);
    // page zero is a usable page, so the flag leaves reset high
    localparam logic PAGE_VALID_RESET = 1'b1;

    logic [7:0] limit_reg;
    logic [7:0] limit_next;
    logic [7:0] page_reg;
    logic [7:0] page_next;
    hpc_pkg::guard_t guard_reg;
    hpc_pkg::guard_t guard_next;
    hpc_pkg::host_rsp_t rsp_reg;
    hpc_pkg::host_rsp_t rsp_next;
    logic [7:0] sat_reg;
    logic [7:0] sat_next;
    logic pvalid_reg;
    logic pvalid_next;
    logic [14:0] iaddr_reg;
    logic [14:0] iaddr_next;
    logic [14:0] full_addr;
    logic hit_guard;
    logic hit_sel;
    logic hit_limit;
    logic any_access;
    logic write_ok;
    logic write_open;

    function automatic logic page_ok(input logic [7:0] p);
        page_ok = (p < hpc_pkg::PAGE_FIRST_RSVD) && (p != hpc_pkg::PAGE_RSVD_A)
            && (p != hpc_pkg::PAGE_RSVD_B);
    endfunction

    // code is already the log encoding; only saturation is applied here
    function automatic logic [7:0] sat_code(input logic [7:0] c);
        sat_code = (c > hpc_pkg::PHASE_MEM_MAX_CODE) ? hpc_pkg::PHASE_MEM_MAX_CODE : c;
    endfunction

    // address decode and access qualifiers
    always_comb
    begin
        full_addr = {page_reg, req.addr};
        // guard and page select ignore the page so a host can never lock itself out
        hit_guard = (req.addr == hpc_pkg::GUARD_LOW_ADDR);
        hit_sel = (req.addr == hpc_pkg::SELECT_LOW_ADDR);
        hit_limit = (full_addr == hpc_pkg::PHASE_MEM_LIMIT_ADDR);
        any_access = req.wr || req.rd;
        // a failed write is dropped before it can touch a data register; the guard still records it in fail
        write_ok = req.wr && !access_fail;
        write_open = write_ok && !guard_reg.lockout;
    end

    // phase-memory limit, stored raw
    always_comb
    begin
        limit_next = limit_reg;
        if (write_open && hit_limit)
        begin
            limit_next = req.wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            limit_reg <= hpc_pkg::PHASE_MEM_LIMIT_RESET;
        end
        else
        begin
            limit_reg <= limit_next;
        end
    end

    // page select
    always_comb
    begin
        page_next = page_reg;
        if (write_open && hit_sel)
        begin
            page_next = req.wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            page_reg <= hpc_pkg::BANK_SELECT_RESET;
        end
        else
        begin
            page_reg <= page_next;
        end
    end

    // port guard: lockout stays writable itself, or it could never be released
    always_comb
    begin
        guard_next = guard_reg;
        if (any_access)
        begin
            guard_next.fail = access_fail;
        end
        if (write_ok && hit_guard)
        begin
            guard_next.lockout = req.wdata[hpc_pkg::LOCKOUT_BIT];
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            guard_reg <= '0;
        end
        else
        begin
            guard_reg <= guard_next;
        end
    end

    // read response; unmapped reads return zero
    always_comb
    begin
        rsp_next.valid = req.rd;
        rsp_next.rdata = '0;
        if (req.rd)
        begin
            if (hit_guard)
            begin
                rsp_next.rdata[hpc_pkg::LOCKOUT_BIT] = guard_reg.lockout;
                rsp_next.rdata[hpc_pkg::FAIL_BIT] = guard_reg.fail;
            end
            else if (hit_sel)
            begin
                rsp_next.rdata = page_reg;
            end
            else if (hit_limit)
            begin
                rsp_next.rdata = limit_reg;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            rsp_reg <= rsp_next;
        end
    end

    // staged views; one cycle of lag is traded for flop-driven outputs
    always_comb
    begin
        sat_next = sat_code(limit_reg);
        pvalid_next = page_ok(page_reg);
        iaddr_next = full_addr;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sat_reg <= hpc_pkg::PHASE_MEM_LIMIT_RESET;
            pvalid_reg <= PAGE_VALID_RESET;
            iaddr_reg <= '0;
        end
        else
        begin
            sat_reg <= sat_next;
            pvalid_reg <= pvalid_next;
            iaddr_reg <= iaddr_next;
        end
    end

    assign rsp = rsp_reg;
    assign phase_mem_code = sat_reg;
    assign page_sel_out = page_reg;
    assign page_valid = pvalid_reg;
    assign int_addr = iaddr_reg;
    assign lockout = guard_reg.lockout;
endmodule
`default_nettype wire

//--- include/hpc_pkg.sv
package hpc_pkg;
    localparam int ADDR_W = 7;
    localparam int PAGE_W = 8;
    localparam int FULL_W = 15;
    localparam logic [6:0] PAGE_SHIFT = 7'h07;
    localparam logic [14:0] PHASE_MEM_LIMIT_ADDR = 15'h059A;
    localparam logic [14:0] PORT_GUARD_ADDR = 15'h05FE;
    localparam logic [14:0] BANK_SELECT_ADDR = 15'h05FF;
    localparam logic [6:0] GUARD_LOW_ADDR = 7'h7E;
    localparam logic [6:0] SELECT_LOW_ADDR = 7'h7F;
    localparam logic [7:0] PHASE_MEM_LIMIT_RESET = 8'h1B;
    localparam logic [7:0] PORT_GUARD_RESET = 8'h00;
    localparam logic [7:0] BANK_SELECT_RESET = 8'h00;
    localparam logic [7:0] PHASE_MEM_MAX_CODE = 8'hA0;
    localparam logic [7:0] PAGE_RSVD_A = 8'h07;
    localparam logic [7:0] PAGE_RSVD_B = 8'h09;
    localparam logic [7:0] PAGE_FIRST_RSVD = 8'h0E;
    localparam int LOCKOUT_BIT = 7;
    localparam int FAIL_BIT = 0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] rdata;
    } host_rsp_t;

    typedef struct packed {
        logic lockout;
        logic fail;
    } guard_t;
endpackage
